//--- rtl/ctg_consts.vh
// constants of the trap group logic: offsets, fields, reset values
// Summary of operation
// - fault pin driven straight from error flag
// - policy: ignore error, or halt the CPU
// - separate handler per group per priority
// - group codes: breakpoint 0, errors 1, sysops 2, scheduler 3
// - breakpoint instruction raises breakpoint trap
// - error group holds overflow and integer fault
// - illegal instruction raises bad-instruction trap
// - handler read/write accesses raise traps
// - low-to-high preemption raises scheduler trap
// - no runnable process raises idle-queue trap
// - one scheduler trap per queueing source
// - scheduler traps come from the microscheduler
// - ready process wptr written to handler workspace
// - software-raised error sets user error flag
// - every trap cause except the user error has its own mask
// - taken trap starts handler, reports cause
// - status/enable bits follow the cause codes
// - trap taken at interruptible point when enabled
// - enabled cause sets status, disabled discarded
`ifndef CTG_CONSTS_VH
`define CTG_CONSTS_VH
// register byte offsets
`define CTG_OFF_CTRL 8'h00
`define CTG_OFF_EN0 8'h04
`define CTG_OFF_EN1 8'h08
`define CTG_OFF_ST0 8'h0c
`define CTG_OFF_ST1 8'h10
`define CTG_OFF_BUSY 8'h14
`define CTG_OFF_SWS0 8'h18
`define CTG_OFF_SWS1 8'h1c
`define CTG_OFF_HND 8'h20
`define CTG_OFF_LAST 8'h40
// control register fields
`define CTG_CTRL_HALT_EN 0
`define CTG_CTRL_ERR 2
`define CTG_CTRL_HALTED 3
`define CTG_CTRL_ERR_CLR 8
// cause bit positions
`define CTG_BIT_BRK 0
`define CTG_BIT_INTF 1
`define CTG_BIT_OVF 2
`define CTG_BIT_BADI 3
`define CTG_BIT_HRD 4
`define CTG_BIT_HWR 5
`define CTG_BIT_SCHED 6
`define CTG_BIT_USER 15
// group codes
`define CTG_GRP_BRK 2'h0
`define CTG_GRP_ERR 2'h1
`define CTG_GRP_SYS 2'h2
`define CTG_GRP_SCH 2'h3
// cause masks of each group
`define CTG_MASK_BRK 16'h0001
`define CTG_MASK_ERR 16'h0006
`define CTG_MASK_SYS 16'h0038
`define CTG_MASK_SCH 16'h3fc0
// scheduler sources that carry a ready process (bits 0..5 of sched_evt)
`define CTG_SCHED_READY 8'h3f
// reset values
`define CTG_RST_EN 16'h0000
`define CTG_RST_WORD 32'h0000_0000
// bus responses
`define CTG_RESP_OKAY 2'h0
`define CTG_RESP_SLVERR 2'h2
`endif

//--- rtl/ctg_cause_vec.v
// raw cause vector of one priority level built from event inputs
`timescale 1ns/10ps
module ctg_cause_vec #(
   parameter PRIO = 0
) (
   // instruction side events, at the current priority
   input wire cur_prio,
   input wire brk_exec,
   input wire int_fault_evt,
   input wire ovf_evt,
   input wire bad_instr_evt,
   input wire hread_evt,
   input wire hwrite_evt,
   input wire user_err_evt,
   // microscheduler events
   input wire sched_prio,
   input wire [7:0] sched_evt,
   // cause vector
   output wire [15:0] raw
);
`include "ctg_consts.vh"
   wire here_i; // instruction event belongs to this level
   wire here_s; // scheduler event belongs to this level
   assign here_i = (cur_prio == PRIO[0]);
   assign here_s = (sched_prio == PRIO[0]);
   // instruction causes go to the running priority
   assign raw[`CTG_BIT_BRK] = here_i & brk_exec;
   assign raw[`CTG_BIT_INTF] = here_i & int_fault_evt;
   assign raw[`CTG_BIT_OVF] = here_i & ovf_evt;
   assign raw[`CTG_BIT_BADI] = here_i & bad_instr_evt;
   assign raw[`CTG_BIT_HRD] = here_i & hread_evt;
   assign raw[`CTG_BIT_HWR] = here_i & hwrite_evt;
   // scheduler causes come from the microscheduler, one per source
   assign raw[13:6] = here_s ? sched_evt : 8'h00;
   assign raw[14] = 1'b0; // unused code
   assign raw[`CTG_BIT_USER] = here_i & user_err_evt;
endmodule // ctg_cause_vec

//--- rtl/ctg_prio_trap.v
// status, busy and pending-group logic of one priority level
`timescale 1ns/10ps
module ctg_prio_trap (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // causes and masks
   input wire [15:0] raw,
   input wire [1:0] ugrp,
   input wire [15:0] enable,
   // software clears
   input wire [15:0] st_w1c,
   input wire [3:0] busy_w1c,
   // trap taken this cycle
   input wire take,
   // state
   output reg [15:0] status,
   output reg [3:0] busy,
   output reg pend_vld,
   output reg [1:0] pend_grp,
   output reg [15:0] pend_cause
);
`include "ctg_consts.vh"
   // cause mask of a group code
   function [15:0] grp_mask;
      input [1:0] g;
      begin
         case (g)
            `CTG_GRP_BRK: grp_mask = `CTG_MASK_BRK;
            `CTG_GRP_ERR: grp_mask = `CTG_MASK_ERR;
            `CTG_GRP_SYS: grp_mask = `CTG_MASK_SYS;
            default: grp_mask = `CTG_MASK_SCH;
         endcase
      end
   endfunction
   reg [3:0] upend_q; // groups flagged by the software error instruction
   reg [3:0] gp; // groups with something pending and not busy
   reg [15:0] set_v; // bits set this cycle
   reg [15:0] clr_v; // bits cleared this cycle
   reg [3:0] uset; // user group set this cycle
   reg [3:0] uclr; // user group cleared this cycle
   integer i;
   // pending group choice, lowest code first
   always @* begin
      gp = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
         gp[i] = (((status & grp_mask(i[1:0])) != 16'h0000) | upend_q[i]) & ~busy[i];
      end
      pend_vld = 1'b0;
      pend_grp = 2'h0;
      for (i = 3; i >= 0; i = i - 1) begin
         if (gp[i]) begin
            pend_vld = 1'b1;
            pend_grp = i[1:0];
         end
      end
      pend_cause = (status & grp_mask(pend_grp)) |
         {upend_q[pend_grp], 15'h0000};
   end
   // status update; a set wins over a clear in the same cycle
   always @* begin
      set_v = raw & enable;
      set_v[`CTG_BIT_USER] = raw[`CTG_BIT_USER];
      uset = raw[`CTG_BIT_USER] ? (4'h1 << ugrp) : 4'h0;
      clr_v = st_w1c;
      uclr = 4'h0;
      if (take) begin
         clr_v = clr_v | grp_mask(pend_grp) | 16'h8000;
         uclr = 4'h1 << pend_grp;
      end
   end
   // registers of this level
   always @(posedge aclk) begin
      if (!aresetn) begin
         status <= 16'h0000;
         upend_q <= 4'h0;
         busy <= 4'h0;
      end else begin
         status <= (status & ~clr_v) | set_v;
         upend_q <= (upend_q & ~uclr) | uset;
         // group stays busy while its handler runs
         busy <= (busy & ~busy_w1c) | (take ? (4'h1 << pend_grp) : 4'h0);
      end
   end
endmodule // ctg_prio_trap

//--- rtl/ctg_trap_unit.v
// trap group logic top: AXI4-Lite registers, error flag, trap dispatch
`timescale 1ns/10ps
module ctg_trap_unit (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // core state
   input wire cur_prio,
   input wire interruptible,
   // instruction events, one-cycle pulses
   input wire brk_exec,
   input wire int_fault_evt,
   input wire ovf_evt,
   input wire bad_instr_evt,
   input wire hread_evt,
   input wire hwrite_evt,
   input wire user_err_evt,
   input wire [1:0] user_err_grp,
   // microscheduler events
   input wire sched_prio,
   input wire [7:0] sched_evt,
   input wire [31:0] ready_wptr,
   // error pin and halt
   output reg fault_indicator_pin,
   output reg cpu_halt,
   // trap dispatch
   output reg trap_take,
   output reg trap_prio,
   output reg [1:0] trap_group,
   output reg [15:0] trap_cause,
   output reg [31:0] trap_handler,
   // workspace write of a ready process
   output reg ws_wr_en,
   output reg [31:0] ws_wr_addr,
   output reg [31:0] ws_wr_data
);
`include "ctg_consts.vh"
   // byte-lane merge of a write into an old word
   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            lane_merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
         end
      end
   endfunction

   // software visible state
   reg halt_en_q; // halt-on-error policy
   reg [15:0] en_q [0:1]; // enables per priority
   reg [31:0] sws_q [0:1]; // scheduler handler workspace per priority
   reg [31:0] hnd_q [0:7]; // handler entry per priority and group
   // bus state
   reg [7:0] awaddr_q; // held write address
   reg aw_hold_q; // write address held
   reg [31:0] wdata_q; // held write data
   reg [3:0] wstrb_q; // held strobes
   reg w_hold_q; // write data held
   reg aw_hold_d;
   reg w_hold_d;
   wire wr_go; // write performed this cycle
   reg wr_hit; // write address mapped
   reg [31:0] rd_v; // read mux
   reg rd_hit; // read address mapped
   // software clears for the level modules
   reg [15:0] st_w1c [0:1];
   reg [3:0] busy_w1c [0:1];
   reg err_clr; // error flag clear by software
   // per level wires
   wire [15:0] raw [0:1];
   wire [15:0] status [0:1];
   wire [3:0] busy [0:1];
   wire pend_vld [0:1];
   wire [1:0] pend_grp [0:1];
   wire [15:0] pend_cause [0:1];
   wire take [0:1];
   wire err_set; // error flag set this cycle
   wire ws_go; // ready process workspace write
   integer j;
   // enable word after a write, cause bits 13:0 only
   wire [31:0] en_wr_v = lane_merge({16'h0000, en_q[awaddr_q[3]]}, wdata_q, wstrb_q) & 32'h3fff;

   // one cause vector and one status block per priority
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : lvl
         ctg_cause_vec #(.PRIO(g)) u_vec (
            .cur_prio(cur_prio),
            .brk_exec(brk_exec),
            .int_fault_evt(int_fault_evt),
            .ovf_evt(ovf_evt),
            .bad_instr_evt(bad_instr_evt),
            .hread_evt(hread_evt),
            .hwrite_evt(hwrite_evt),
            .user_err_evt(user_err_evt),
            .sched_prio(sched_prio),
            .sched_evt(sched_evt),
            .raw(raw[g])
         );
         ctg_prio_trap u_lvl (
            .aclk(aclk),
            .aresetn(aresetn),
            .raw(raw[g]),
            .ugrp(user_err_grp),
            .enable(en_q[g]),
            .st_w1c(st_w1c[g]),
            .busy_w1c(busy_w1c[g]),
            .take(take[g]),
            .status(status[g]),
            .busy(busy[g]),
            .pend_vld(pend_vld[g]),
            .pend_grp(pend_grp[g]),
            .pend_cause(pend_cause[g])
         );
         // trap taken only at an interruptible point of this level
         assign take[g] = pend_vld[g] & interruptible & (cur_prio == g) & ~cpu_halt;
      end
   endgenerate

   // error flag sources: arithmetic faults and the error instruction
   assign err_set = ovf_evt | int_fault_evt | user_err_evt;
   // ready process reported by an enabled queueing source
   assign ws_go = |(sched_evt & `CTG_SCHED_READY & en_q[sched_prio][13:6]);

   // write channel holding: address and data taken in either order
   assign wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   always @* begin
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      if (s_axi_awvalid & s_axi_awready) begin
         aw_hold_d = 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         w_hold_d = 1'b1;
      end
      if (wr_go) begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
      end
   end

   // write decode and software clear strobes
   always @* begin
      wr_hit = 1'b0;
      err_clr = 1'b0;
      st_w1c[0] = 16'h0000;
      st_w1c[1] = 16'h0000;
      busy_w1c[0] = 4'h0;
      busy_w1c[1] = 4'h0;
      if (wr_go) begin
         case (awaddr_q)
            `CTG_OFF_CTRL: begin
               wr_hit = 1'b1;
               err_clr = wstrb_q[1] & wdata_q[`CTG_CTRL_ERR_CLR];
            end
            `CTG_OFF_EN0, `CTG_OFF_EN1, `CTG_OFF_SWS0, `CTG_OFF_SWS1: begin
               wr_hit = 1'b1;
            end
            `CTG_OFF_ST0: begin
               wr_hit = 1'b1;
               st_w1c[0] = wdata_q[15:0];
            end
            `CTG_OFF_ST1: begin
               wr_hit = 1'b1;
               st_w1c[1] = wdata_q[15:0];
            end
            `CTG_OFF_BUSY: begin
               // handler exit frees its group
               wr_hit = 1'b1;
               busy_w1c[0] = wdata_q[3:0];
               busy_w1c[1] = wdata_q[7:4];
            end
            default: begin
               wr_hit = (awaddr_q[7:5] == 3'h1) & (awaddr_q[1:0] == 2'h0);
            end
         endcase
      end
   end

   // read decode
   always @* begin
      rd_v = `CTG_RST_WORD;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `CTG_OFF_CTRL: begin
            rd_v[`CTG_CTRL_HALT_EN] = halt_en_q;
            rd_v[`CTG_CTRL_ERR] = fault_indicator_pin;
            rd_v[`CTG_CTRL_HALTED] = cpu_halt;
         end
         `CTG_OFF_EN0: rd_v[15:0] = en_q[0];
         `CTG_OFF_EN1: rd_v[15:0] = en_q[1];
         `CTG_OFF_ST0: rd_v[15:0] = status[0];
         `CTG_OFF_ST1: rd_v[15:0] = status[1];
         `CTG_OFF_BUSY: rd_v[7:0] = {busy[1], busy[0]};
         `CTG_OFF_SWS0: rd_v = sws_q[0];
         `CTG_OFF_SWS1: rd_v = sws_q[1];
         `CTG_OFF_LAST: rd_v = {13'h0000, trap_prio, trap_group, trap_cause};
         default: begin
            // handler table, index prio*4 + group
            rd_hit = (s_axi_araddr[7:5] == 3'h1) & (s_axi_araddr[1:0] == 2'h0);
            rd_v = rd_hit ? hnd_q[s_axi_araddr[4:2]] : `CTG_RST_WORD;
         end
      endcase
   end

   // bus channel registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= `CTG_RST_WORD;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CTG_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `CTG_RESP_OKAY;
         s_axi_rdata <= `CTG_RST_WORD;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         // ready whenever the holding slot is free next cycle
         s_axi_awready <= ~aw_hold_d;
         s_axi_wready <= ~w_hold_d;
         if (s_axi_awvalid & s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         // write response follows both channels
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CTG_RESP_OKAY : `CTG_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // read: address taken, data one cycle later
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_v;
            s_axi_rresp <= rd_hit ? `CTG_RESP_OKAY : `CTG_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // software writable registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         halt_en_q <= 1'b0;
         for (j = 0; j < 2; j = j + 1) begin
            en_q[j] <= `CTG_RST_EN;
            sws_q[j] <= `CTG_RST_WORD;
         end
         for (j = 0; j < 8; j = j + 1) begin
            hnd_q[j] <= `CTG_RST_WORD;
         end
      end else if (wr_go) begin
         case (awaddr_q)
            `CTG_OFF_CTRL: begin
               if (wstrb_q[0]) begin
                  halt_en_q <= wdata_q[`CTG_CTRL_HALT_EN];
               end
            end
            `CTG_OFF_EN0, `CTG_OFF_EN1: en_q[awaddr_q[3]] <= en_wr_v[15:0];
            `CTG_OFF_SWS0: sws_q[0] <= lane_merge(sws_q[0], wdata_q, wstrb_q);
            `CTG_OFF_SWS1: sws_q[1] <= lane_merge(sws_q[1], wdata_q, wstrb_q);
            default: begin
               if (wr_hit & (awaddr_q[7:5] == 3'h1)) begin
                  hnd_q[awaddr_q[4:2]] <= lane_merge(hnd_q[awaddr_q[4:2]], wdata_q, wstrb_q);
               end
            end
         endcase
      end
   end

   // error flag, its pin and the halt policy
   always @(posedge aclk) begin
      if (!aresetn) begin
         fault_indicator_pin <= 1'b0;
         cpu_halt <= 1'b0;
      end else begin
         // a new error wins over a software clear
         fault_indicator_pin <= err_set | (fault_indicator_pin & ~(err_clr & ~cpu_halt));
         // stop one cycle after the flag, held until reset
         cpu_halt <= cpu_halt | (halt_en_q & fault_indicator_pin);
      end
   end

   // trap dispatch: handler of the taken level and group
   always @(posedge aclk) begin
      if (!aresetn) begin
         trap_take <= 1'b0;
         trap_prio <= 1'b0;
         trap_group <= `CTG_GRP_BRK;
         trap_cause <= 16'h0000;
         trap_handler <= `CTG_RST_WORD;
      end else begin
         trap_take <= take[0] | take[1];
         if (take[0] | take[1]) begin
            trap_prio <= take[1];
            trap_group <= pend_grp[take[1]];
            trap_cause <= pend_cause[take[1]];
            trap_handler <= hnd_q[{take[1], pend_grp[take[1]]}];
         end
      end
   end

   // scheduler handler workspace word 0 receives the ready process
   always @(posedge aclk) begin
      if (!aresetn) begin
         ws_wr_en <= 1'b0;
         ws_wr_addr <= `CTG_RST_WORD;
         ws_wr_data <= `CTG_RST_WORD;
      end else begin
         ws_wr_en <= ws_go;
         if (ws_go) begin
            ws_wr_addr <= sws_q[sched_prio];
            ws_wr_data <= ready_wptr;
         end
      end
   end
endmodule // ctg_trap_unit

//--- bench/ctg_trap_unit_sva.sv
// assertion checker of the trap group logic, bound to the top module
`timescale 1ns/10ps
`include "ctg_consts.vh"
module ctg_trap_chk (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   // core state and events
   input wire cur_prio,
   input wire interruptible,
   input wire int_fault_evt,
   input wire ovf_evt,
   input wire user_err_evt,
   input wire [7:0] sched_evt,
   input wire [31:0] ready_wptr,
   // error pin, halt and dispatch
   input wire fault_indicator_pin,
   input wire cpu_halt,
   input wire trap_take,
   input wire trap_prio,
   input wire [1:0] trap_group,
   input wire [15:0] trap_cause,
   input wire ws_wr_en,
   input wire [31:0] ws_wr_data
);
   // causes that may belong to the reported group
   wire [15:0] grp_mask = (trap_group == `CTG_GRP_BRK) ? `CTG_MASK_BRK :
      (trap_group == `CTG_GRP_ERR) ? `CTG_MASK_ERR :
      (trap_group == `CTG_GRP_SYS) ? `CTG_MASK_SYS : `CTG_MASK_SCH;
   // sources that carry a ready process
   wire [5:0] ready_src = sched_evt[5:0];
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // address and data accepted at one edge
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // read address accepted
   sequence s_rd_addr;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_FAULT_PIN:
   assert property ((ovf_evt || int_fault_evt || user_err_evt) |=> fault_indicator_pin)
      else $error("fault pin not raised after error event");
   AST_HALT_KEEP:
   assert property (cpu_halt |=> cpu_halt)
      else $error("halt released before reset");
   AST_HALT_CAUSE:
   assert property ($rose(cpu_halt) |-> $past(fault_indicator_pin))
      else $error("halt without error flag");
   AST_HALT_NO_TAKE:
   assert property ($past(cpu_halt) |-> !trap_take)
      else $error("trap taken while halted");
   AST_TAKE_POINT:
   assert property (trap_take |-> $past(interruptible) && (trap_prio == $past(cur_prio)))
      else $error("trap taken outside interruptible point or at wrong level");
   AST_TAKE_GROUP:
   assert property (trap_take |-> (trap_cause & 16'h7fff & ~grp_mask) == 16'h0000)
      else $error("cause outside reported group");
   AST_WS_WRITE:
   assert property (ws_wr_en |-> ($past(ready_src) != 6'h00) && (ws_wr_data == $past(ready_wptr)))
      else $error("workspace write without ready process");
   AST_WR_RESP:
   assert property (s_wr_both |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_RD_RESP:
   assert property (s_rd_addr |=> s_axi_rvalid)
      else $error("read data late");
   AST_AR_BLOCK:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
endmodule // ctg_trap_chk
bind ctg_trap_unit ctg_trap_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .cur_prio(cur_prio), .interruptible(interruptible),
   .int_fault_evt(int_fault_evt), .ovf_evt(ovf_evt), .user_err_evt(user_err_evt),
   .sched_evt(sched_evt), .ready_wptr(ready_wptr), .fault_indicator_pin(fault_indicator_pin),
   .cpu_halt(cpu_halt), .trap_take(trap_take), .trap_prio(trap_prio),
   .trap_group(trap_group), .trap_cause(trap_cause), .ws_wr_en(ws_wr_en),
   .ws_wr_data(ws_wr_data));

//--- bench/tb.sv
// self-checking testbench of the trap group logic
`timescale 1ns/10ps
`include "ctg_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("FAIL %0t: got %h exp %h", $time, (g), (e)); end end
module tb;
   // bus side
   logic aclk, aresetn, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, rdv;
   logic [1:0] br, rr, rsp;
   // core side
   logic cur, intr, ue, fpin, halt, take, tprio, wse;
   logic [1:0] ugrp, tgrp;
   logic [5:0] ev;
   logic [7:0] sev;
   logic [15:0] tcause;
   logic [31:0] wptr, hnd, wsa, wsd;
   int mismatches = 0;
   int check_count = 0;
   ctg_trap_unit uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .cur_prio(cur), .interruptible(intr), .brk_exec(ev[0]), .int_fault_evt(ev[1]),
      .ovf_evt(ev[2]), .bad_instr_evt(ev[3]), .hread_evt(ev[4]), .hwrite_evt(ev[5]),
      .user_err_evt(ue), .user_err_grp(ugrp), .sched_prio(cur), .sched_evt(sev),
      .ready_wptr(wptr), .fault_indicator_pin(fpin), .cpu_halt(halt), .trap_take(take),
      .trap_prio(tprio), .trap_group(tgrp), .trap_cause(tcause), .trap_handler(hnd),
      .ws_wr_en(wse), .ws_wr_addr(wsa), .ws_wr_data(wsd));
   // free-running core clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // verdict and end of run
   task conclude;
      if (mismatches == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // bus write: both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ah, wh, done;
      done = 1'b0;
      @(posedge aclk);
      awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
      repeat (50) if (!done) begin
         @(negedge aclk);
         ah = awv && awr;
         wh = wv && wrd;
         done = bv;
         rsp = br;
         @(posedge aclk);
         if (ah) awv <= 1'b0;
         if (wh) wv <= 1'b0;
         if (done) bry <= 1'b0;
      end
   endtask
   // bus read: data and response left in rdv and rsp
   task automatic rd(input logic [7:0] a);
      logic ah, done;
      done = 1'b0;
      @(posedge aclk);
      ara <= a; arv <= 1'b1; rry <= 1'b1;
      repeat (50) if (!done) begin
         @(negedge aclk);
         ah = arv && arr;
         done = rv;
         rdv = rdat;
         rsp = rr;
         @(posedge aclk);
         if (ah) arv <= 1'b0;
         if (done) rry <= 1'b0;
      end
   endtask
   // one-cycle instruction and scheduler event pulses
   task pulse(input logic [5:0] e, input logic [7:0] s);
      @(posedge aclk);
      ev <= e; sev <= s;
      @(posedge aclk);
      ev <= 6'h00; sev <= 8'h00;
   endtask
   // wait for a dispatch, judge it, then free its group
   task automatic take_chk(input logic [1:0] g, input logic [15:0] c, input logic p);
      logic seen;
      seen = 1'b0;
      repeat (10) if (!seen) @(negedge aclk) seen = (take === 1'b1);
      `CHK(seen, 1'b1)
      `CHK(tgrp, g)
      `CHK(tcause, c)
      `CHK(tprio, p)
      wr(`CTG_OFF_BUSY, 32'h1 << {p, g});
   endtask
   // reset values and an unmapped place
   task t_reset;
      rd(`CTG_OFF_CTRL); `CHK(rdv, 32'h0000_0000)
      rd(`CTG_OFF_EN0); `CHK(rdv, 32'h0000_0000)
      rd(`CTG_OFF_ST0); `CHK(rdv, 32'h0000_0000)
      rd(8'hfc); `CHK(rsp, `CTG_RESP_SLVERR)
      wr(8'hfc, 32'h0000_0000); `CHK(rsp, `CTG_RESP_SLVERR)
   endtask
   // every instruction cause but the user error, then every scheduler cause
   task automatic t_groups;
      wr(`CTG_OFF_SWS0, 32'h0000_1000);
      wr(`CTG_OFF_EN0, 32'h0000_3fff);
      for (int i = 0; i < 6; i++) begin
         pulse(6'h01 << i, 8'h00);
         take_chk((i == 0) ? 2'h0 : (i < 3) ? 2'h1 : 2'h2, 16'h0001 << i, 1'b0);
         `CHK(fpin, (i == 1 || i == 2))
         `CHK(halt, 1'b0)
         wr(`CTG_OFF_CTRL, 32'h0000_0100);
      end
      for (int j = 0; j < 8; j++) begin
         @(posedge aclk);
         wptr <= 32'h0000_0400 + j;
         pulse(6'h00, 8'h01 << j);
         @(negedge aclk);
         `CHK(wse, (j < 6))
         if (j < 6) `CHK(wsd, 32'h0000_0400 + j)
         if (j < 6) `CHK(wsa, 32'h0000_1000)
         take_chk(2'h3, 16'h0040 << j, 1'b0);
      end
   endtask
   // masked cause discarded, then pending until interruptible
   task t_mask_intr;
      wr(`CTG_OFF_EN0, 32'h0000_0000);
      pulse(6'h01, 8'h00);
      repeat (4) @(negedge aclk) `CHK(take, 1'b0)
      rd(`CTG_OFF_ST0); `CHK(rdv, 32'h0000_0000)
      @(posedge aclk);
      intr <= 1'b0;
      wr(`CTG_OFF_EN0, 32'h0000_0001);
      pulse(6'h01, 8'h00);
      repeat (4) @(negedge aclk) `CHK(take, 1'b0)
      rd(`CTG_OFF_ST0); `CHK(rdv, 32'h0000_0001)
      @(posedge aclk);
      intr <= 1'b1;
      take_chk(2'h0, 16'h0001, 1'b0);
   endtask
   // software-raised error in the system group
   task t_user;
      @(posedge aclk);
      intr <= 1'b0; ue <= 1'b1; ugrp <= 2'h2;
      @(posedge aclk);
      ue <= 1'b0;
      @(negedge aclk);
      `CHK(fpin, 1'b1)
      rd(`CTG_OFF_ST0); `CHK(rdv, 32'h0000_8000)
      @(posedge aclk);
      intr <= 1'b1;
      take_chk(2'h2, 16'h8000, 1'b0);
      wr(`CTG_OFF_CTRL, 32'h0000_0100);
   endtask
   // low level with its own handler entry
   task t_prio;
      @(posedge aclk);
      cur <= 1'b1;
      wr(`CTG_OFF_EN1, 32'h0000_0041);
      wr(`CTG_OFF_SWS1, 32'h0000_2000);
      wr(`CTG_OFF_HND + 8'h10, 32'h0000_beef);
      pulse(6'h01, 8'h00);
      take_chk(2'h0, 16'h0001, 1'b1);
      `CHK(hnd, 32'h0000_beef)
      pulse(6'h00, 8'h01);
      @(negedge aclk);
      `CHK(wsa, 32'h0000_2000)
      take_chk(2'h3, 16'h0040, 1'b1);
      @(posedge aclk);
      cur <= 1'b0;
   endtask
   // halt on error holds until a reset in mid-run
   task t_halt;
      wr(`CTG_OFF_CTRL, 32'h0000_0001);
      wr(`CTG_OFF_EN0, 32'h0000_3fff);
      pulse(6'h04, 8'h00);
      repeat (2) @(negedge aclk);
      `CHK(halt, 1'b1)
      pulse(6'h01, 8'h00);
      repeat (6) @(negedge aclk) `CHK(take, 1'b0)
      `CHK(halt, 1'b1)
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      `CHK(halt, 1'b0)
      `CHK(fpin, 1'b0)
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      conclude;
   end
   // main sequence
   initial begin
      aresetn = 1'b0; awv = 1'b0; wv = 1'b0; bry = 1'b0; arv = 1'b0; rry = 1'b0;
      awa = 8'h00; ara = 8'h00; wd = 32'h0; wptr = 32'h0; ev = 6'h00; sev = 8'h00;
      cur = 1'b0; intr = 1'b1; ue = 1'b0; ugrp = 2'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_groups;
      t_mask_intr;
      t_user;
      t_prio;
      t_halt;
      conclude;
   end
endmodule // tb
